// ===== hdl/cns_nmt_slave.sv
// canopen slave: pdo mapping store, boot-up, node guarding, heartbeat
// How it works
// - count subindex gives entries; zero disables
// - receive pdos preset 200h-500h plus node
// - transmit pdos preset 180h-480h plus node
// - pre-operational entry sends 700h+node, byte 00
// - boot-up frame unconfirmed, no acknowledge awaited
// - boot-up frame suppressible by configuration bit
// - guarding and heartbeat never both active
// - remote request 700h+node gets one response
// - response holds state bits 6-0, toggling bit 7
// - guard time in milliseconds is stored
// - life time is guard time times factor
// - response sent within life time, correct content
// - nonzero heartbeat period sends state cyclically
// - no consumer time stored in slave
// - cob changes apply only at restart
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module cns_nmt_slave #(
  parameter int          CYC_MS  = cns_pkg::CYC_PER_MS,
  parameter logic [6:0]  NODE_ID = 7'h01
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // axi4-lite write
  input  wire logic [15:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // axi4-lite read
  input  wire logic [15:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // received remote requests from the can controller
  input  wire logic         rtr_valid,
  input  wire logic [10:0]  rtr_id,
  // frames to the can controller
  output logic              tx_valid,
  output logic [10:0]       tx_id,
  output logic [3:0]        tx_dlc,
  output logic [7:0]        tx_data,
  input  wire logic         tx_ready,
  // pdo configuration towards the process-data engine
  output logic [7:0][10:0]  pdo_cob_id,
  output logic [7:0]        pdo_active,
  output logic [6:0]        nmt_state
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic              awr_reg, awr_next, bv_reg, bv_next, arr_reg, arr_next;
  logic              rv_reg, rv_next;
  logic [1:0]        br_reg, br_next, rr_reg, rr_next;
  logic [31:0]       rd_reg, rd_next;
  logic [15:0]       guard_reg, guard_next, hb_reg, hb_next;
  logic [7:0]        life_reg, life_next;
  logic [6:0]        state_reg, state_next, node_cfg_reg, node_cfg_next;
  logic [6:0]        node_reg, node_next;
  logic              supp_reg, supp_next, tog_reg, tog_next;
  logic              lerr_reg, lerr_next;
  logic [4:0]        sel_reg, sel_next;
  logic [7:0][7:0]   cnt_reg, cnt_next;
  logic [7:0][3:0][31:0] ent_reg, ent_next;
  logic [7:0]        inv_cfg_reg, inv_cfg_next, inv_reg, inv_next;
  logic [7:0][10:0]  cob_reg, cob_next;
  logic [7:0]        act_reg, act_next;
  logic              boot_p_reg, boot_p_next, grd_p_reg, grd_p_next;
  logic              hb_p_reg, hb_p_next;
  logic              txv_reg, txv_next;
  logic [10:0]       txid_reg, txid_next;
  logic [7:0]        txd_reg, txd_next;
  logic [15:0]       cyc_reg, cyc_next, hbms_reg, hbms_next;
  logic              tick_reg, tick_next;
  logic [23:0]       lms_reg, lms_next;
  logic              arm_reg, arm_next;

  // merge written bytes into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for bus, configuration and frame services
  always_comb
  begin
    logic        wr, hit_w, hit_r, restart, guard_on;
    logic [31:0] w, rv;
    logic [2:0]  p;
    logic [1:0]  e;
    logic [23:0] life_lim;
    wr = awr_reg;
    w  = 32'h0;
    rv = 32'h0;
    hit_w = 1'b1;
    hit_r = 1'b1;
    restart = 1'b0;
    p = sel_reg[2:0];
    e = sel_reg[4:3];
    awr_next = awr_reg; bv_next = bv_reg; br_next = br_reg;
    arr_next = arr_reg; rv_next = rv_reg; rr_next = rr_reg; rd_next = rd_reg;
    guard_next = guard_reg; life_next = life_reg; hb_next = hb_reg;
    state_next = state_reg; node_cfg_next = node_cfg_reg; node_next = node_reg;
    supp_next = supp_reg; tog_next = tog_reg; lerr_next = lerr_reg;
    sel_next = sel_reg; cnt_next = cnt_reg; ent_next = ent_reg;
    inv_cfg_next = inv_cfg_reg; inv_next = inv_reg; cob_next = cob_reg;
    boot_p_next = boot_p_reg; grd_p_next = grd_p_reg; hb_p_next = hb_p_reg;
    txv_next = txv_reg; txid_next = txid_reg; txd_next = txd_reg;
    cyc_next = cyc_reg; hbms_next = hbms_reg; tick_next = 1'b0;
    lms_next = lms_reg; arm_next = arm_reg;
    // mutual exclusion: a running heartbeat disables guarding
    guard_on = (hb_reg == 16'h0);
    life_lim = guard_reg * life_reg;

    // write channel: address and data are taken together, one word per beat
    awr_next = s_axi_awvalid && s_axi_wvalid && !awr_reg && !bv_reg;
    if (bv_reg && s_axi_bready)
      bv_next = 1'b0;
    if (wr)
    begin
      bv_next = 1'b1;
      unique case ({s_axi_awaddr[15:2], 2'b00})
        cns_pkg::A_GUARD: guard_next = 16'(merge({16'h0, guard_reg},
                                       s_axi_wdata, s_axi_wstrb));
        cns_pkg::A_LIFE:  life_next = 8'(merge({24'h0, life_reg},
                                      s_axi_wdata, s_axi_wstrb));
        cns_pkg::A_HBEAT: hb_next = 16'(merge({16'h0, hb_reg},
                                    s_axi_wdata, s_axi_wstrb));
        cns_pkg::A_CTRL:
        begin
          w = merge({22'h0, supp_reg, 2'b00, state_reg}, s_axi_wdata,
                    s_axi_wstrb);
          state_next = w[6:0];
          supp_next  = w[cns_pkg::CTRL_SUPPRESS];
          restart    = w[cns_pkg::CTRL_RESTART];
        end
        cns_pkg::A_NODE:  node_cfg_next = s_axi_wstrb[0] ? s_axi_wdata[6:0]
                                                         : node_cfg_reg;
        cns_pkg::A_STAT:
          if (s_axi_wstrb[1] && s_axi_wdata[cns_pkg::ST_LIFE_ERR])
            lerr_next = 1'b0;
        cns_pkg::A_SEL:   sel_next = s_axi_wstrb[0] ? s_axi_wdata[4:0] : sel_reg;
        cns_pkg::A_COUNT: cnt_next[p] = s_axi_wstrb[0] ? s_axi_wdata[7:0]
                                                       : cnt_reg[p];
        cns_pkg::A_ENTRY: ent_next[p][e] = merge(ent_reg[p][e], s_axi_wdata,
                                                 s_axi_wstrb);
        cns_pkg::A_COBID:
          if (s_axi_wstrb[3])
            inv_cfg_next[p] = s_axi_wdata[cns_pkg::COB_VALID];
        default: hit_w = 1'b0;
      endcase
      br_next = hit_w ? cns_pkg::RESP_OKAY : cns_pkg::RESP_SLVERR;
    end

    // read channel: one word answered the cycle after the address is taken
    arr_next = s_axi_arvalid && !arr_reg && !rv_reg;
    if (rv_reg && s_axi_rready)
      rv_next = 1'b0;
    if (arr_reg)
    begin
      unique case ({s_axi_araddr[15:2], 2'b00})
        cns_pkg::A_GUARD: rv = {16'h0, guard_reg};
        cns_pkg::A_LIFE:  rv = {24'h0, life_reg};
        cns_pkg::A_HBEAT: rv = {16'h0, hb_reg};
        cns_pkg::A_CTRL:  rv = {22'h0, supp_reg, 2'b00, state_reg};
        cns_pkg::A_NODE:  rv = {9'h0, node_reg, 9'h0, node_cfg_reg};
        cns_pkg::A_STAT:  rv = {22'h0, txv_reg, lerr_reg, tog_reg, state_reg};
        cns_pkg::A_SEL:   rv = {27'h0, sel_reg};
        cns_pkg::A_COUNT: rv = {24'h0, cnt_reg[p]};
        cns_pkg::A_ENTRY: rv = ent_reg[p][e];
        cns_pkg::A_COBID: rv = {inv_cfg_reg[p], 20'h0, cob_reg[p]};
        default:          hit_r = 1'b0;
      endcase
      rv_next = 1'b1;
      rd_next = rv;
      rr_next = hit_r ? cns_pkg::RESP_OKAY : cns_pkg::RESP_SLVERR;
    end

    // millisecond time base shared by heartbeat and life-time watch
    if (cyc_reg == 16'(CYC_MS - 1))
    begin
      cyc_next  = 16'h0;
      tick_next = 1'b1;
    end
    else
      cyc_next = cyc_reg + 16'h1;

    // transmit: one frame held until the controller takes it, no reply
    // is ever awaited for boot-up or heartbeat
    if (txv_reg && tx_ready)
      txv_next = 1'b0;
    if (!txv_reg || tx_ready)
    begin
      if (boot_p_reg)
      begin
        txv_next    = 1'b1;
        txid_next   = cns_pkg::COB_NMT_ERR + 11'(node_reg);
        txd_next    = cns_pkg::BOOT_DATA;
        boot_p_next = 1'b0;
      end
      else if (grd_p_reg)
      begin
        txv_next   = 1'b1;
        txid_next  = cns_pkg::COB_NMT_ERR + 11'(node_reg);
        txd_next   = {tog_reg, state_reg};
        tog_next   = !tog_reg;
        grd_p_next = 1'b0;
      end
      else if (hb_p_reg)
      begin
        txv_next  = 1'b1;
        txid_next = cns_pkg::COB_NMT_ERR + 11'(node_reg);
        txd_next  = {1'b0, state_reg};
        hb_p_next = 1'b0;
      end
    end

    // guarding: matching remote request queues exactly one response
    if (rtr_valid && guard_on &&
        rtr_id == cns_pkg::COB_NMT_ERR + 11'(node_reg))
    begin
      grd_p_next = 1'b1;
      lms_next   = 24'h0;
      arm_next   = (life_lim != 24'h0);
    end
    else if (tick_reg && arm_reg)
    begin
      // the master's polling is watched; a miss latches the error bit
      if (lms_reg + 24'h1 >= life_lim)
      begin
        lerr_next = 1'b1;
        arm_next  = 1'b0;
      end
      else
        lms_next = lms_reg + 24'h1;
    end
    if (!guard_on)
      arm_next = 1'b0;

    // heartbeat producer; only the period is held, no consumer time
    if (hb_reg == 16'h0)
      hbms_next = 16'h0;
    else if (tick_reg)
    begin
      if (hbms_reg + 16'h1 >= hb_reg)
      begin
        hbms_next = 16'h0;
        hb_p_next = 1'b1;
      end
      else
        hbms_next = hbms_reg + 16'h1;
    end

    // communication restart: identifiers take effect here, not on the write
    if (restart)
    begin
      node_next   = node_cfg_next;
      inv_next    = inv_cfg_next;
      for (int i = 0; i < 8; i++)
        cob_next[i] = cns_pkg::COB_PDO[i] + 11'(node_cfg_next);
      state_next  = cns_pkg::NMT_PREOP;
      tog_next    = 1'b0;
      boot_p_next = !supp_next;
      grd_p_next  = 1'b0;
    end
  end

  // a pdo is live only with a nonzero count and a clear valid bit
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      act_next[i] = (cnt_reg[i] != 8'h0) && !inv_reg[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; reset enters pre-operational and queues a boot-up frame
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awr_reg <= 1'b0; bv_reg <= 1'b0; br_reg <= cns_pkg::RESP_OKAY;
      arr_reg <= 1'b0; rv_reg <= 1'b0; rr_reg <= cns_pkg::RESP_OKAY;
      rd_reg <= 32'h0;
      guard_reg <= 16'h0; life_reg <= 8'h0; hb_reg <= 16'h0;
      state_reg <= cns_pkg::NMT_PREOP;
      node_cfg_reg <= NODE_ID; node_reg <= NODE_ID;
      supp_reg <= 1'b0; tog_reg <= 1'b0; lerr_reg <= 1'b0;
      sel_reg <= 5'h0;
      cnt_reg <= cns_pkg::MAP_CNT_RST;
      ent_reg <= cns_pkg::MAP_PRESET;
      inv_cfg_reg <= 8'h0; inv_reg <= 8'h0;
      for (int i = 0; i < 8; i++)
        cob_reg[i] <= cns_pkg::COB_PDO[i] + 11'(NODE_ID);
      act_reg <= 8'h0;
      boot_p_reg <= 1'b1; grd_p_reg <= 1'b0; hb_p_reg <= 1'b0;
      txv_reg <= 1'b0; txid_reg <= 11'h0; txd_reg <= 8'h0;
      cyc_reg <= 16'h0; tick_reg <= 1'b0; hbms_reg <= 16'h0;
      lms_reg <= 24'h0; arm_reg <= 1'b0;
    end
    else
    begin
      awr_reg <= awr_next; bv_reg <= bv_next; br_reg <= br_next;
      arr_reg <= arr_next; rv_reg <= rv_next; rr_reg <= rr_next;
      rd_reg <= rd_next;
      guard_reg <= guard_next; life_reg <= life_next; hb_reg <= hb_next;
      state_reg <= state_next;
      node_cfg_reg <= node_cfg_next; node_reg <= node_next;
      supp_reg <= supp_next; tog_reg <= tog_next; lerr_reg <= lerr_next;
      sel_reg <= sel_next; cnt_reg <= cnt_next; ent_reg <= ent_next;
      inv_cfg_reg <= inv_cfg_next; inv_reg <= inv_next; cob_reg <= cob_next;
      act_reg <= act_next;
      boot_p_reg <= boot_p_next; grd_p_reg <= grd_p_next;
      hb_p_reg <= hb_p_next;
      txv_reg <= txv_next; txid_reg <= txid_next; txd_reg <= txd_next;
      cyc_reg <= cyc_next; tick_reg <= tick_next; hbms_reg <= hbms_next;
      lms_reg <= lms_next; arm_reg <= arm_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops except tx_dlc, which is a constant
  assign s_axi_awready = awr_reg;
  assign s_axi_wready  = awr_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rresp   = rr_reg;
  assign s_axi_rdata   = rd_reg;
  assign tx_valid      = txv_reg;
  assign tx_id         = txid_reg;
  assign tx_dlc        = cns_pkg::DLC_ONE;  // every frame here is one byte
  assign tx_data       = txd_reg;
  assign pdo_cob_id    = cob_reg;
  assign pdo_active    = act_reg;
  assign nmt_state     = state_reg;

endmodule // cns_nmt_slave
`default_nettype wire

// ===== hdl/cns_pkg.sv
// constants shared by the canopen slave network-management block
package cns_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  // object indices; byte address is four times the index
  localparam logic [15:0] IDX_GUARD = 16'h100C;
  localparam logic [15:0] IDX_LIFE  = 16'h100D;
  localparam logic [15:0] IDX_HBEAT = 16'h1017;
  localparam logic [15:0] A_GUARD   = {IDX_GUARD[13:0], 2'b00};
  localparam logic [15:0] A_LIFE    = {IDX_LIFE[13:0], 2'b00};
  localparam logic [15:0] A_HBEAT   = {IDX_HBEAT[13:0], 2'b00};
  localparam logic [15:0] A_CTRL    = 16'h0000;
  localparam logic [15:0] A_NODE    = 16'h0004;
  localparam logic [15:0] A_STAT    = 16'h0008;
  localparam logic [15:0] A_SEL     = 16'h000C;
  localparam logic [15:0] A_COUNT   = 16'h0010;
  localparam logic [15:0] A_ENTRY   = 16'h0014;
  localparam logic [15:0] A_COBID   = 16'h0018;
  // field positions
  localparam int CTRL_RESTART  = 8;
  localparam int CTRL_SUPPRESS = 9;
  localparam int ST_TOGGLE     = 7;
  localparam int ST_LIFE_ERR   = 8;
  localparam int ST_BUSY       = 9;
  localparam int COB_VALID     = 31;
  // nmt state codes
  localparam logic [6:0] NMT_STOPPED = 7'h04;
  localparam logic [6:0] NMT_OPER    = 7'h05;
  localparam logic [6:0] NMT_PREOP   = 7'h7F;
  // frame identifiers; pdo 0..3 transmit, 4..7 receive
  localparam logic [10:0] COB_NMT_ERR = 11'h700;
  localparam logic [7:0][10:0] COB_PDO = {11'h500, 11'h400, 11'h300, 11'h200,
                                          11'h480, 11'h380, 11'h280, 11'h180};
  localparam logic [7:0] BOOT_DATA = 8'h00;
  localparam logic [3:0] DLC_ONE   = 4'h1;
  // preset mapping entries <index><subindex><bit length>
  localparam logic [7:0][3:0][31:0] MAP_PRESET = {
    {32'h0, 32'h0, 32'h0, 32'h60FE0120},
    {32'h0, 32'h0, 32'h0, 32'h60420010},
    {32'h0, 32'h0, 32'h60810020, 32'h607A0020},
    {32'h0, 32'h32020220, 32'h60600008, 32'h60400010},
    {32'h0, 32'h0, 32'h0, 32'h60FD0020},
    {32'h0, 32'h0, 32'h0, 32'h60440010},
    {32'h0, 32'h0, 32'h0, 32'h60640020},
    {32'h0, 32'h0, 32'h60610008, 32'h60410010}};
  localparam logic [7:0][7:0] MAP_CNT_RST = {8'h01, 8'h01, 8'h02, 8'h03,
                                             8'h01, 8'h01, 8'h01, 8'h02};
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== sim/cns_master_model.sv
// behavioural nmt master on the far side of the can controller
`timescale 1ns/100ps
`default_nettype none
module cns_master_model (
  // clock and stall control
  input  wire logic        aclk,
  input  wire logic        slow,
  // remote requests towards the slave
  output logic             rtr_valid,
  output logic [10:0]      rtr_id,
  // frames from the slave
  input  wire logic        tx_valid,
  input  wire logic [10:0] tx_id,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready
);
  logic [31:0] stamp;
  logic [50:0] frames[$];
  initial
  begin
    rtr_valid = 1'b0;
    rtr_id = 11'h000;
    tx_ready = 1'b0;
    stamp = 32'h0;
  end
  // one-cycle request; the id lines are scrambled once released
  task automatic poll(input logic [10:0] id);
    rtr_valid <= 1'b1;
    rtr_id <= id;
    @(posedge aclk);
    rtr_valid <= 1'b0;
    rtr_id <= ~id;
  endtask
  // log every frame taken; nothing is ever confirmed back to the slave
  always @(posedge aclk)
  begin
    stamp <= stamp + 1;
    if (tx_valid && tx_ready) frames.push_back({stamp, tx_id, tx_data});
    tx_ready <= !slow || stamp[1:0] == 2'b11;
  end
endmodule // cns_master_model
`default_nettype wire

// ===== sim/cns_nmt_props.sv
// assertion checker for the canopen slave network-management block
`timescale 1ns/100ps
`default_nettype none
module cns_nmt_props #(
  parameter logic [6:0] NODE_ID = 7'h01
) (
  // clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // register bus
  input wire logic [15:0]      s_axi_awaddr,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic [31:0]      s_axi_wdata,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  // can side
  input wire logic             rtr_valid,
  input wire logic [10:0]      rtr_id,
  input wire logic             tx_valid,
  input wire logic [10:0]      tx_id,
  input wire logic [3:0]       tx_dlc,
  input wire logic [7:0]       tx_data,
  input wire logic             tx_ready,
  input wire logic [7:0][10:0] pdo_cob_id,
  input wire logic [7:0]       pdo_active,
  input wire logic [6:0]       nmt_state
);
  logic [10:0]      nmt_id;
  logic [7:0][10:0] cob_exp;
  logic             hb_zero;
  logic             hb_next;
  assign nmt_id = cns_pkg::COB_NMT_ERR + {4'h0, NODE_ID};
  // preset identifiers, the node id folded in
  always_comb
    for (int i = 0; i < 8; i++) cob_exp[i] = cns_pkg::COB_PDO[i] + {4'h0, NODE_ID};
  // shadow of the heartbeat period: zero means guarding may answer
  always_comb
  begin
    hb_next = hb_zero;
    if (s_axi_awready && s_axi_awaddr == cns_pkg::A_HBEAT)
      hb_next = (s_axi_wdata[15:0] == 16'h0000);
  end
  always_ff @(posedge aclk)
    hb_zero <= !aresetn ? 1'b1 : hb_next;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  AST_BOOT_FRAME: assert property ($rose(aresetn) |=> tx_valid && tx_id == nmt_id
    && tx_data == cns_pkg::BOOT_DATA) else $error("no boot-up frame after reset");
  AST_PRESET_IDS: assert property ($rose(aresetn) |-> ##2 pdo_cob_id == cob_exp
    && pdo_active == 8'hFF) else $error("preset pdo identifiers wrong");
  AST_ONE_BYTE: assert property (tx_valid |-> tx_dlc == cns_pkg::DLC_ONE)
    else $error("frame length not one byte");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid
    && $stable(tx_id) && $stable(tx_data)) else $error("frame dropped before taken");
  AST_STATE_BITS: assert property (tx_valid && tx_data[6:0] != 7'h00
    |-> tx_data[6:0] == nmt_state) else $error("frame state field wrong");
  AST_GUARD_REPLY: assert property (rtr_valid && rtr_id == nmt_id && hb_zero && !tx_valid
    |-> ##2 tx_valid && tx_id == nmt_id) else $error("remote request not answered");
  AST_HB_NO_TOGGLE: assert property (tx_valid && !hb_zero |-> !tx_data[7])
    else $error("heartbeat carries toggle bit");
  AST_AXI_WRITE: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  AST_AXI_READ: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready ##1 s_axi_rvalid) else $error("read answer late");
  AST_RERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == cns_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("refused read returns data");
endmodule // cns_nmt_props
bind cns_nmt_slave cns_nmt_props #(.NODE_ID(NODE_ID)) u_props (.*);
`default_nettype wire

// ===== sim/tb_top.sv
// testbench for the canopen slave network-management block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int          CYC = 10;
  localparam logic [10:0] NID = 11'h705;
  logic aclk, aresetn, slow, rtr_valid, tx_valid, tx_ready;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, t0;
  logic [3:0] s_axi_wstrb, tx_dlc;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [10:0] rtr_id, tx_id;
  logic [7:0] tx_data, pdo_active;
  logic [7:0][10:0] pdo_cob_id;
  logic [6:0] nmt_state;
  logic [50:0] f;
  int errors, n_checks, cyc;
  cns_nmt_slave #(.CYC_MS(CYC), .NODE_ID(7'h05)) uut (.*);
  cns_master_model partner (.*);
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    chk(nm, e, rd & m);
  endtask
  // bounded wait for the next frame, then compare identifier and byte
  task automatic frame(input logic [18:0] e);
    for (int n = 0; n < 300 && partner.frames.size() == 0; n++) @(posedge aclk);
    f = partner.frames.size() > 0 ? partner.frames.pop_front() : 51'h0;
    chk("frame", {13'h0, e}, {13'h0, f[18:0]});
  endtask
  task automatic quiet(input int n);
    repeat (n) @(posedge aclk);
    chk("frames", 32'h0, 32'(partner.frames.size()));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 34'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {errors, n_checks, cyc} = 96'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    frame({NID, cns_pkg::BOOT_DATA});
    for (int i = 0; i < 8; i++) chk("cob", cns_pkg::COB_PDO[i] + 32'h5, pdo_cob_id[i]);
    chk("active", 32'hFF, pdo_active);
    rchk("guard", cns_pkg::A_GUARD, 32'hFFFF, 32'h0);
    rchk("life", cns_pkg::A_LIFE, 32'hFF, 32'h0);
    rchk("hbeat", cns_pkg::A_HBEAT, 32'hFFFF, 32'h0);
    rchk("status", cns_pkg::A_STAT, 32'h1FF, 32'h7F);
    rchk("unmapped", 16'h0100, 32'hFFFFFFFF, 32'h0);
    chk("rresp", cns_pkg::RESP_SLVERR, rs);
    wr(16'h0100, 32'hFFFFFFFF);
    chk("bresp", cns_pkg::RESP_SLVERR, rs);
    // guarding against a stalling master; a foreign id gets no answer
    slow <= 1'b1;
    partner.poll(NID + 11'h1);
    quiet(20);
    for (int i = 0; i < 3; i++)
    begin
      partner.poll(NID);
      frame({NID, i[0], 7'h7F});
    end
    // life time of 2 ms times 2
    slow <= 1'b0;
    wr(cns_pkg::A_GUARD, 32'h2);
    wr(cns_pkg::A_LIFE, 32'h2);
    rchk("guard", cns_pkg::A_GUARD, 32'hFFFF, 32'h2);
    partner.poll(NID);
    frame({NID, 8'hFF});
    repeat (25) @(posedge aclk);
    partner.poll(NID);
    frame({NID, 8'h7F});
    rchk("lifeok", cns_pkg::A_STAT, 32'h100, 32'h0);
    repeat (60) @(posedge aclk);
    rchk("lifeerr", cns_pkg::A_STAT, 32'h100, 32'h100);
    // the watch is disarmed after a miss, so a clear must stick
    wr(cns_pkg::A_STAT, 32'h100);
    rchk("lifeclr", cns_pkg::A_STAT, 32'h100, 32'h0);
    // switch supervision over to heartbeat in the operational state
    wr(cns_pkg::A_CTRL, 32'h05);
    wr(cns_pkg::A_HBEAT, 32'h3);
    frame({NID, 8'h05});
    t0 = f[50:19];
    frame({NID, 8'h05});
    chk("period", 3 * CYC, f[50:19] - t0);
    partner.poll(NID);
    quiet(10);
    wr(cns_pkg::A_HBEAT, 32'h0);
    repeat (5) @(posedge aclk);
    partner.frames.delete();
    quiet(100);
    // remap transmit pdo 0 in the prescribed order
    wr(cns_pkg::A_SEL, 32'h0);
    rchk("count", cns_pkg::A_COUNT, 32'hFF, 32'h2);
    rchk("entry", cns_pkg::A_ENTRY, 32'hFFFFFFFF, 32'h60410010);
    wr(cns_pkg::A_COBID, 32'h80000000);
    chk("pend", 32'h1, pdo_active[0]);
    wr(cns_pkg::A_COUNT, 32'h0);
    chk("off", 32'h0, pdo_active[0]);
    wr(cns_pkg::A_ENTRY, 32'h60640020);
    wr(cns_pkg::A_COUNT, 32'h1);
    rchk("entry", cns_pkg::A_ENTRY, 32'hFFFFFFFF, 32'h60640020);
    wr(cns_pkg::A_CTRL, 32'h300);
    chk("invalid", 32'h0, pdo_active[0]);
    chk("state", 32'h7F, nmt_state);
    quiet(20);
    wr(cns_pkg::A_COBID, 32'h0);
    wr(cns_pkg::A_CTRL, 32'h100);
    frame({NID, cns_pkg::BOOT_DATA});
    chk("on", 32'h1, pdo_active[0]);
    // second hardware reset restores the presets
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    frame({NID, cns_pkg::BOOT_DATA});
    rchk("count", cns_pkg::A_COUNT, 32'hFF, 32'h2);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
